// ==== irb_bridge.sv ====
// Indirect register access bridge: analog window and APB window
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module irb_bridge
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	input  wire logic [9:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic             o_ana_hdmi_sel,
	output logic             o_ana_ser_sel,
	output logic             o_ana_wr,
	output logic             o_ana_rd,
	output logic [7:0]       o_ana_addr,
	output logic [7:0]       o_ana_wdata,
	input  wire logic [7:0]  i_ana_rdata,
	input  wire logic        i_ana_ack,
	output logic [1:0]       o_apb_target,
	output logic             o_apb_psel,
	output logic             o_apb_penable,
	output logic             o_apb_pwrite,
	output logic [15:0]      o_apb_paddr,
	output logic [31:0]      o_apb_pwdata,
	input  wire logic [31:0] i_apb_prdata,
	input  wire logic        i_apb_pready,
	input  wire logic        i_apb_pslverr
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	irb_pkg::irb_bus_e bus_r;
	logic [2:0]  ana_sel_r;
	logic        ana_auto_r;
	logic        ana_dir_r;
	logic [7:0]  ana_ofs_r;
	logic [7:0]  ana_dat_r;
	logic [1:0]  apb_sel_r;
	logic        apb_auto_r;
	logic        apb_rd_r;
	logic        apb_en_r;
	logic [15:0] apb_addr_r;
	logic [31:0] apb_data_r;
	logic [7:0]  idx;
	logic [7:0]  wd;
	logic        host_wr;
	logic        host_rd;
	logic        ana_valid;
	logic        ana_go;
	logic        rd_launch;
	logic        wr_launch;
	logic        apb_busy;
	logic        apb_done;
	logic        apb_done_wr;
	logic        apb_err;
	logic [31:0] apb_rdata;
	logic [7:0]  rd_val;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Only the low byte lane carries register data
	assign idx     = i_avs_address[9:irb_pkg::IDX_LSB];
	assign wd      = i_avs_writedata[7:0];
	assign host_wr = (bus_r == irb_pkg::BUS_IDLE) && i_avs_write && i_avs_byteenable[0];
	assign host_rd = (bus_r == irb_pkg::BUS_IDLE) && i_avs_read;

	// Only two analog codes lead anywhere
	// target code decode
	assign ana_valid = (ana_sel_r == irb_pkg::ANA_TGT_HDMI) || (ana_sel_r == irb_pkg::ANA_TGT_SER);

	// Data register access goes indirect in the programmed direction
	// direction picks access
	assign ana_go = ana_valid && (idx == irb_pkg::IDX_ANA_DAT)
		&& ((host_wr && !ana_dir_r) || (host_rd && ana_dir_r));

	// Read-start takes the freshly written enable and target
	// read-start launches read
	assign rd_launch = host_wr && (idx == irb_pkg::IDX_APB_PORT_CONTROL) && wd[irb_pkg::APB_EN_BIT]
		&& wd[irb_pkg::APB_RD_BIT] && !apb_busy;

	// Writing the top data byte pushes the whole word out
	// read-only targets refuse
	assign wr_launch = host_wr && (idx == irb_pkg::IDX_DAT3) && apb_en_r
		&& irb_pkg::apb_writable(apb_sel_r) && !apb_busy;

	// Read mux; unmapped indices read as zero
	always_comb
	begin
		rd_val = irb_pkg::RST_BYTE;
		case (idx)
			irb_pkg::IDX_ANA_CTL: rd_val = {3'h0, ana_sel_r, ana_auto_r, ana_dir_r};
			irb_pkg::IDX_ANA_OFS: rd_val = ana_ofs_r;
			irb_pkg::IDX_ANA_DAT: rd_val = ana_dat_r;
			irb_pkg::IDX_APB_PORT_CONTROL: rd_val = {3'h0, apb_sel_r, apb_auto_r, apb_rd_r, apb_en_r};
			irb_pkg::IDX_ADR_LO:  rd_val = apb_addr_r[7:0];
			irb_pkg::IDX_ADR_HI:  rd_val = apb_addr_r[15:8];
			irb_pkg::IDX_DAT0:    rd_val = apb_data_r[7:0];
			irb_pkg::IDX_DAT1:    rd_val = apb_data_r[15:8];
			irb_pkg::IDX_DAT2:    rd_val = apb_data_r[23:16];
			irb_pkg::IDX_DAT3:    rd_val = apb_data_r[31:24];
			default:              rd_val = irb_pkg::RST_BYTE;
		endcase
	end

	// ----------------------------------------
	// Avalon slave sequencing
	// ----------------------------------------
	// Waitrequest idles high and drops for exactly one answer cycle
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			bus_r             <= irb_pkg::BUS_IDLE;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= irb_pkg::RST_WORD;
		end
		else
		begin
			case (bus_r)
				irb_pkg::BUS_IDLE:
					if (ana_go)
						bus_r <= irb_pkg::BUS_ANA;
					else if (i_avs_read || i_avs_write)
					begin
						o_avs_waitrequest <= 1'b0;
						o_avs_readdata    <= {24'h0, rd_val};
						bus_r             <= irb_pkg::BUS_RESP;
					end
				irb_pkg::BUS_ANA:
					if (i_ana_ack)
					begin
						o_avs_waitrequest <= 1'b0;
						o_avs_readdata    <= {24'h0, o_ana_rd ? i_ana_rdata : ana_dat_r};
						bus_r             <= irb_pkg::BUS_RESP;
					end
				irb_pkg::BUS_RESP:
				begin
					o_avs_waitrequest <= 1'b1;
					bus_r             <= irb_pkg::BUS_IDLE;
				end
				default:
					bus_r <= irb_pkg::BUS_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Analog window
	// ----------------------------------------
	// Control register
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			ana_sel_r  <= irb_pkg::ANA_TGT_NONE;
			ana_auto_r <= 1'b0;
			ana_dir_r  <= 1'b0;
		end
		else if (host_wr && idx == irb_pkg::IDX_ANA_CTL)
		begin
			ana_sel_r  <= wd[irb_pkg::ANA_SEL_LSB +: 3];
			ana_auto_r <= wd[irb_pkg::ANA_AUTO_BIT];
			ana_dir_r  <= wd[irb_pkg::ANA_DIR_BIT];
		end
	end

	// Offset; software writes never meet an ack, both need distinct states
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
			ana_ofs_r <= irb_pkg::RST_BYTE;
		else if (host_wr && idx == irb_pkg::IDX_ANA_OFS)
			ana_ofs_r <= wd;
		else if (bus_r == irb_pkg::BUS_ANA && i_ana_ack && ana_auto_r)
			ana_ofs_r <= ana_ofs_r + irb_pkg::ANA_STEP;
	end

	// Data byte keeps the last value written or read back
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
			ana_dat_r <= irb_pkg::RST_BYTE;
		else if (host_wr && idx == irb_pkg::IDX_ANA_DAT)
			ana_dat_r <= wd;
		else if (bus_r == irb_pkg::BUS_ANA && i_ana_ack && o_ana_rd)
			ana_dat_r <= i_ana_rdata;
	end

	// Strobes stand from launch until the block acknowledges
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			o_ana_hdmi_sel <= 1'b0;
			o_ana_ser_sel  <= 1'b0;
			o_ana_wr       <= 1'b0;
			o_ana_rd       <= 1'b0;
			o_ana_addr     <= irb_pkg::RST_BYTE;
			o_ana_wdata    <= irb_pkg::RST_BYTE;
		end
		else if (ana_go)
		begin
			o_ana_hdmi_sel <= (ana_sel_r == irb_pkg::ANA_TGT_HDMI);
			o_ana_ser_sel  <= (ana_sel_r == irb_pkg::ANA_TGT_SER);
			o_ana_wr       <= !ana_dir_r;
			o_ana_rd       <= ana_dir_r;
			o_ana_addr     <= ana_ofs_r;
			o_ana_wdata    <= wd;
		end
		else if (bus_r == irb_pkg::BUS_ANA && i_ana_ack)
		begin
			o_ana_hdmi_sel <= 1'b0;
			o_ana_ser_sel  <= 1'b0;
			o_ana_wr       <= 1'b0;
			o_ana_rd       <= 1'b0;
		end
	end

	// ----------------------------------------
	// APB window
	// ----------------------------------------
	// Control bits; read-start set wins over the hardware clear
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			apb_sel_r  <= irb_pkg::APB_TGT_HDMI;
			apb_auto_r <= 1'b0;
			apb_en_r   <= 1'b0;
			apb_rd_r   <= 1'b0;
		end
		else
		begin
			if (host_wr && idx == irb_pkg::IDX_APB_PORT_CONTROL)
			begin
				apb_sel_r  <= wd[irb_pkg::APB_SEL_LSB +: 2];
				apb_auto_r <= wd[irb_pkg::APB_AUTO_BIT];
				apb_en_r   <= wd[irb_pkg::APB_EN_BIT];
			end
			if (apb_done && !apb_done_wr)
				apb_rd_r <= 1'b0;
			if (rd_launch)
				apb_rd_r <= 1'b1;
		end
	end

	// Address bytes; a software write lands after any step
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
			apb_addr_r <= irb_pkg::RST_HALF;
		else
		begin
			if (apb_done && apb_auto_r)
				apb_addr_r <= apb_addr_r + irb_pkg::apb_step(o_apb_target);
			if (host_wr && idx == irb_pkg::IDX_ADR_LO)
				apb_addr_r[7:0] <= wd;
			if (host_wr && idx == irb_pkg::IDX_ADR_HI)
				apb_addr_r[15:8] <= wd;
		end
	end

	// Data word; an errored read leaves it untouched
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
			apb_data_r <= irb_pkg::RST_WORD;
		else
		begin
			if (apb_done && !apb_done_wr && !apb_err)
				apb_data_r <= apb_rdata;
			if (host_wr && idx == irb_pkg::IDX_DAT0)
				apb_data_r[7:0] <= wd;
			if (host_wr && idx == irb_pkg::IDX_DAT1)
				apb_data_r[15:8] <= wd;
			if (host_wr && idx == irb_pkg::IDX_DAT2)
				apb_data_r[23:16] <= wd;
			if (host_wr && idx == irb_pkg::IDX_DAT3)
				apb_data_r[31:24] <= wd;
		end
	end

	// Sequencer; the write word merges the byte being written now
	irb_apb_master u_apb
	(
		.i_ref_clk    (i_ref_clk),
		.i_nrst       (i_nrst),
		.i_start      (rd_launch || wr_launch),
		.i_write      (wr_launch),
		.i_target     (rd_launch ? wd[irb_pkg::APB_SEL_LSB +: 2] : apb_sel_r),
		.i_addr       (apb_addr_r),
		.i_wdata      ({wd, apb_data_r[23:0]}),
		.i_prdata     (i_apb_prdata),
		.i_pready     (i_apb_pready),
		.i_pslverr    (i_apb_pslverr),
		.o_busy       (apb_busy),
		.o_done       (apb_done),
		.o_done_write (apb_done_wr),
		.o_err        (apb_err),
		.o_rdata      (apb_rdata),
		.o_target     (o_apb_target),
		.o_psel       (o_apb_psel),
		.o_penable    (o_apb_penable),
		.o_pwrite     (o_apb_pwrite),
		.o_paddr      (o_apb_paddr),
		.o_pwdata     (o_apb_pwdata)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	chk_ana_one_target: assert property (
		(o_ana_wr || o_ana_rd) |-> (o_ana_hdmi_sel != o_ana_ser_sel))
		else $error("analog access without a single target");

	chk_ana_offset_step: assert property (
		(bus_r == irb_pkg::BUS_ANA && i_ana_ack)
		|=> ana_ofs_r == ($past(ana_ofs_r) + ($past(ana_auto_r) ? 8'h01 : 8'h00)))
		else $error("analog offset step wrong");

	chk_ana_dir_match: assert property (
		($rose(o_ana_wr) |-> !ana_dir_r) and ($rose(o_ana_rd) |-> ana_dir_r))
		else $error("analog direction mismatch");

	chk_ana_addr_out: assert property (
		$rose(o_ana_wr || o_ana_rd) |-> o_ana_addr == $past(ana_ofs_r))
		else $error("analog offset not driven");

	chk_ana_wr_byte: assert property (
		$rose(o_ana_wr) |-> o_ana_wdata == ana_dat_r)
		else $error("analog write byte differs from data register");

	chk_ana_rd_return: assert property (
		(bus_r == irb_pkg::BUS_ANA && i_ana_ack && o_ana_rd)
		|=> !o_avs_waitrequest && o_avs_readdata[7:0] == $past(i_ana_rdata))
		else $error("analog read data not returned");

	chk_apb_ro_target: assert property (
		(o_apb_psel && o_apb_pwrite) |-> !o_apb_target[1])
		else $error("write to read-only target");

	chk_apb_addr_step: assert property (
		(apb_done && apb_auto_r && !host_wr)
		|=> apb_addr_r == $past(apb_addr_r) + (($past(o_apb_target) == 2'h0) ? 16'h0004 : 16'h0001))
		else $error("APB address step wrong");

	chk_apb_rd_clear: assert property (
		(apb_done && !apb_done_wr && !apb_err && !host_wr)
		|=> !apb_rd_r && apb_data_r == $past(apb_rdata))
		else $error("read-start not cleared with data loaded");

	chk_apb_en_addr: assert property (
		$rose(o_apb_psel) |-> apb_en_r && o_apb_paddr == $past(apb_addr_r))
		else $error("APB access disabled or wrong address");

	chk_bus_answer: assert property (
		!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("answer held more than one cycle");

endmodule
`default_nettype wire

// ==== irb_pkg.sv ====
// Constants and types shared by the indirect register access bridge
`default_nettype none
package irb_pkg;

	// ----------------------------------------
	// Register indices (byte address is 4x)
	// ----------------------------------------
	localparam logic [7:0] IDX_ANA_CTL = 8'h40;
	localparam logic [7:0] IDX_ANA_OFS = 8'h41;
	localparam logic [7:0] IDX_ANA_DAT = 8'h42;
	localparam logic [7:0] IDX_APB_PORT_CONTROL = 8'h48;
	localparam logic [7:0] IDX_ADR_LO  = 8'h49;
	localparam logic [7:0] IDX_ADR_HI  = 8'h4a;
	localparam logic [7:0] IDX_DAT0    = 8'h4b;
	localparam logic [7:0] IDX_DAT1    = 8'h4c;
	localparam logic [7:0] IDX_DAT2    = 8'h4d;
	localparam logic [7:0] IDX_DAT3    = 8'h4e;
	localparam int         IDX_LSB     = 2;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ANA_SEL_LSB  = 2;
	localparam int ANA_AUTO_BIT = 1;
	localparam int ANA_DIR_BIT  = 0;
	localparam int APB_SEL_LSB  = 3;
	localparam int APB_AUTO_BIT = 2;
	localparam int APB_RD_BIT   = 1;
	localparam int APB_EN_BIT   = 0;

	// ----------------------------------------
	// Target codes, steps and reset values
	// ----------------------------------------
	localparam logic [2:0]  ANA_TGT_NONE = 3'h0;
	localparam logic [2:0]  ANA_TGT_HDMI = 3'h4;
	localparam logic [2:0]  ANA_TGT_SER  = 3'h5;
	localparam logic [1:0]  APB_TGT_HDMI = 2'h0;
	localparam logic [1:0]  APB_TGT_EDID = 2'h1;
	localparam logic [7:0]  ANA_STEP     = 8'h01;
	localparam logic [15:0] APB_STEP_HDMI  = 16'h0004;
	localparam logic [15:0] APB_STEP_OTHER = 16'h0001;
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_HALF     = 16'h0000;
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;

	typedef enum {BUS_IDLE, BUS_ANA, BUS_RESP} irb_bus_e;
	typedef enum {APB_IDLE, APB_SETUP, APB_ACCESS} irb_apb_e;

	// Address step after a finished APB access
	function automatic logic [15:0] apb_step(input logic [1:0] tgt);
		apb_step = (tgt == APB_TGT_HDMI) ? APB_STEP_HDMI : APB_STEP_OTHER;
	endfunction

	// Only the controller and the SRAM accept writes
	function automatic logic apb_writable(input logic [1:0] tgt);
		apb_writable = (tgt == APB_TGT_HDMI) || (tgt == APB_TGT_EDID);
	endfunction

endpackage
`default_nettype wire

// ==== irb_apb_master.sv ====
// APB master sequencer for the indirect APB window
`timescale 1ns/100ps
`default_nettype none
module irb_apb_master
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_start,
	input  wire logic        i_write,
	input  wire logic [1:0]  i_target,
	input  wire logic [15:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_done_write,
	output logic             o_err,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_target,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic [15:0]      o_paddr,
	output logic [31:0]      o_pwdata
);

	irb_pkg::irb_apb_e state_r;

	// Busy also covers the done cycle so the caller sees settled registers
	assign o_busy = (state_r != irb_pkg::APB_IDLE) || o_done;

	// Setup, access, wait for ready
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			state_r      <= irb_pkg::APB_IDLE;
			o_psel       <= 1'b0;
			o_penable    <= 1'b0;
			o_pwrite     <= 1'b0;
			o_paddr      <= irb_pkg::RST_HALF;
			o_pwdata     <= irb_pkg::RST_WORD;
			o_target     <= 2'h0;
			o_done       <= 1'b0;
			o_done_write <= 1'b0;
			o_err        <= 1'b0;
			o_rdata      <= irb_pkg::RST_WORD;
		end
		else
		begin
			o_done <= 1'b0;
			case (state_r)
				irb_pkg::APB_IDLE:
					if (i_start && !o_busy)
					begin
						o_psel   <= 1'b1;
						o_pwrite <= i_write;
						o_paddr  <= i_addr;
						o_pwdata <= i_wdata;
						o_target <= i_target;
						state_r  <= irb_pkg::APB_SETUP;
					end
				irb_pkg::APB_SETUP:
				begin
					o_penable <= 1'b1;
					state_r   <= irb_pkg::APB_ACCESS;
				end
				irb_pkg::APB_ACCESS:
					if (i_pready)
					begin
						o_psel       <= 1'b0;
						o_penable    <= 1'b0;
						o_done       <= 1'b1;
						o_done_write <= o_pwrite;
						o_err        <= i_pslverr;
						o_rdata      <= i_prdata;
						state_r      <= irb_pkg::APB_IDLE;
					end
				default:
					state_r <= irb_pkg::APB_IDLE;
			endcase
		end
	end

	// Enable follows select by exactly one cycle
	chk_apb_phase_order: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		$rose(o_psel) |=> o_psel && o_penable)
		else $error("enable did not follow select");

endmodule
`default_nettype wire

// ==== irb_far_model.sv ====
// Far-side model: analog register blocks and APB slave
`timescale 1ns/100ps
`default_nettype none
module irb_far_model
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	input  wire logic [3:0]  i_slow,
	input  wire logic        i_err,
	input  wire logic        i_ana_hdmi_sel,
	input  wire logic        i_ana_ser_sel,
	input  wire logic        i_ana_wr,
	input  wire logic        i_ana_rd,
	input  wire logic [7:0]  i_ana_addr,
	input  wire logic [7:0]  i_ana_wdata,
	output logic [7:0]       o_ana_rdata,
	output logic             o_ana_ack,
	input  wire logic [1:0]  i_apb_target,
	input  wire logic        i_apb_psel,
	input  wire logic        i_apb_penable,
	input  wire logic        i_apb_pwrite,
	input  wire logic [15:0] i_apb_paddr,
	input  wire logic [31:0] i_apb_pwdata,
	output logic [31:0]      o_apb_prdata,
	output logic             o_apb_pready,
	output logic             o_apb_pslverr
);
	logic [7:0]  ana_mem [2][256];
	logic [31:0] apb_mem [4][16];
	logic [3:0]  ana_cnt_r;
	logic [3:0]  apb_cnt_r;

	// Known contents so every read has a figure to match
	initial
	begin
		foreach (ana_mem[s, a])
			ana_mem[s][a] = 8'h00;
		foreach (apb_mem[t, a])
			apb_mem[t][a] = 32'h5a5a_0000 + 32'(t * 256 + a);
	end

	// Analog blocks: ack after a chosen stall; data flips outside the ack cycle
	always @(posedge i_ref_clk)
	begin
		o_ana_ack   <= 1'b0;
		o_ana_rdata <= i_nrst ? ~o_ana_rdata : 8'h00;
		ana_cnt_r   <= 4'h0;
		if (i_nrst && (i_ana_wr || i_ana_rd) && (i_ana_hdmi_sel || i_ana_ser_sel) && !o_ana_ack)
		begin
			ana_cnt_r <= ana_cnt_r + 4'h1;
			if (ana_cnt_r >= i_slow)
			begin
				o_ana_ack   <= 1'b1;
				o_ana_rdata <= ana_mem[i_ana_ser_sel][i_ana_addr];
				if (i_ana_wr)
					ana_mem[i_ana_ser_sel][i_ana_addr] <= i_ana_wdata;
			end
		end
	end

	// APB slave: stores any write it is handed without an error, read-only targets too
	always @(posedge i_ref_clk)
	begin
		o_apb_pready  <= 1'b0;
		o_apb_pslverr <= 1'b0;
		o_apb_prdata  <= i_nrst ? ~o_apb_prdata : 32'h0;
		apb_cnt_r     <= 4'h0;
		if (i_nrst && i_apb_psel && i_apb_penable && !o_apb_pready)
		begin
			apb_cnt_r <= apb_cnt_r + 4'h1;
			if (apb_cnt_r >= i_slow)
			begin
				o_apb_pready  <= 1'b1;
				o_apb_pslverr <= i_err;
				o_apb_prdata  <= apb_mem[i_apb_target][i_apb_paddr[3:0]];
				if (i_apb_pwrite && !i_err)
					apb_mem[i_apb_target][i_apb_paddr[3:0]] <= i_apb_pwdata;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test_irb_bridge.sv ====
// Self-checking testbench for the indirect register access bridge
`timescale 1ns/100ps
`default_nettype none
module test_irb_bridge;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  slow = 4'h0;
	logic        err = 1'b0;
	logic [31:0] rdat, q, pwdat, prdat;
	logic        wreq, hsel, ssel, awr, ard, aack, psel, pen, pwr, prdy, perr;
	logic [7:0]  aadr, awdat, ardat;
	logic [1:0]  tgt;
	logic [15:0] padr;
	int          miscompares = 0;
	int          total_checks = 0;

	always #5 clk = ~clk;

	irb_bridge u_irb_bridge (.i_ref_clk(clk), .i_nrst(nrst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'h1),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_ana_hdmi_sel(hsel),
		.o_ana_ser_sel(ssel), .o_ana_wr(awr), .o_ana_rd(ard), .o_ana_addr(aadr),
		.o_ana_wdata(awdat), .i_ana_rdata(ardat), .i_ana_ack(aack), .o_apb_target(tgt),
		.o_apb_psel(psel), .o_apb_penable(pen), .o_apb_pwrite(pwr), .o_apb_paddr(padr),
		.o_apb_pwdata(pwdat), .i_apb_prdata(prdat), .i_apb_pready(prdy), .i_apb_pslverr(perr));

	irb_far_model u_irb_far_model (.i_ref_clk(clk), .i_nrst(nrst), .i_slow(slow), .i_err(err),
		.i_ana_hdmi_sel(hsel), .i_ana_ser_sel(ssel), .i_ana_wr(awr), .i_ana_rd(ard),
		.i_ana_addr(aadr), .i_ana_wdata(awdat), .o_ana_rdata(ardat), .o_ana_ack(aack),
		.i_apb_target(tgt), .i_apb_psel(psel), .i_apb_penable(pen), .i_apb_pwrite(pwr),
		.i_apb_paddr(padr), .i_apb_pwdata(pwdat), .o_apb_prdata(prdat), .o_apb_pready(prdy),
		.o_apb_pslverr(perr));

	// Count and report one comparison
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Print counts and verdict, then stop
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// One Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		adr  <= {idx, 2'b00};
		wdat <= {24'h0, d};
		rd   <= !w;
		wr   <= w;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wreq !== 1'b0 && n < 300);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 300)
		begin
			miscompares++;
			give_verdict();
		end
		@(posedge clk);
	endtask

	// Read a register and compare the whole word
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check($sformatf("reg %h", idx), {24'h0, exp}, q);
	endtask

	// Poll the read-start bit until the bridge clears it
	task automatic poll_done;
		int n;
		n = 0;
		do
		begin
			bus(1'b0, 8'h48, 8'h00);
			n++;
		end
		while (q[1] !== 1'b0 && n < 50);
		check("read-start clear", 32'h0, {31'h0, q[1]});
	endtask

	// Reset values and an unmapped place
	task automatic t_reset;
		logic [7:0] regs [10] = '{8'h40, 8'h41, 8'h42, 8'h48, 8'h49,
			8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e};
		foreach (regs[i])
			rchk(regs[i], 8'h00);
		bus(1'b1, 8'h50, 8'h5c);
		rchk(8'h50, 8'h00);
	endtask

	// Analog writes: offset wrap with autostep, then serializer without it
	task automatic t_ana_write;
		bus(1'b1, 8'h40, 8'h12);
		bus(1'b1, 8'h41, 8'hff);
		bus(1'b1, 8'h42, 8'ha5);
		check("hdmi reg", 8'ha5, u_irb_far_model.ana_mem[0][255]);
		rchk(8'h41, 8'h00);
		bus(1'b1, 8'h40, 8'h14);
		bus(1'b1, 8'h41, 8'h80);
		slow <= 4'h3;
		bus(1'b1, 8'h42, 8'h3c);
		check("ser reg", 8'h3c, u_irb_far_model.ana_mem[1][128]);
		check("hdmi kept", 8'h00, u_irb_far_model.ana_mem[0][128]);
		rchk(8'h41, 8'h80);
	endtask

	// Analog reads and direction gating of data writes
	task automatic t_ana_read;
		bus(1'b1, 8'h40, 8'h15);
		rchk(8'h42, 8'h3c);
		bus(1'b1, 8'h42, 8'h99);
		check("dir read no write", 8'h3c, u_irb_far_model.ana_mem[1][128]);
		bus(1'b1, 8'h41, 8'hff);
		bus(1'b1, 8'h40, 8'h13);
		rchk(8'h42, 8'ha5);
		rchk(8'h41, 8'h00);
		slow <= 4'h0;
	endtask

	// Disabled and reserved analog codes move nothing
	task automatic t_ana_reserved;
		for (int c = 0; c < 8; c++)
		begin
			if (c == 4 || c == 5)
				continue;
			bus(1'b1, 8'h40, {3'b000, 3'(c), 2'b10});
			bus(1'b1, 8'h41, 8'h10);
			bus(1'b1, 8'h42, 8'h77);
			check("hdmi idle", 8'h00, u_irb_far_model.ana_mem[0][16]);
			check("ser idle", 8'h00, u_irb_far_model.ana_mem[1][16]);
			rchk(8'h41, 8'h10);
		end
	endtask

	// APB reads on all targets with autostep, across a byte boundary on the HDMI target only
	task automatic t_apb_read;
		for (int t = 0; t < 4; t++)
		begin
			bus(1'b1, 8'h49, 8'hfc);
			bus(1'b1, 8'h4a, 8'h12);
			slow <= 4'(t);
			bus(1'b1, 8'h48, {3'b000, 2'(t), 3'b111});
			poll_done();
			rchk(8'h4b, 8'h0c);
			rchk(8'h4c, 8'(t));
			rchk(8'h4d, 8'h5a);
			rchk(8'h4e, 8'h5a);
			rchk(8'h49, t == 0 ? 8'h00 : 8'hfd);
			rchk(8'h4a, t == 0 ? 8'h13 : 8'h12);
			rchk(8'h48, {3'b000, 2'(t), 3'b101});
		end
		slow <= 4'h0;
	endtask

	// APB writes: read-only targets refuse, address held without autostep
	task automatic t_apb_write;
		int n;
		for (int t = 0; t < 4; t++)
		begin
			bus(1'b1, 8'h48, {3'b000, 2'(t), 3'b001});
			bus(1'b1, 8'h49, 8'h05);
			bus(1'b1, 8'h4a, 8'h00);
			bus(1'b1, 8'h4b, 8'h90);
			bus(1'b1, 8'h4c, 8'ha1);
			bus(1'b1, 8'h4d, 8'hb2);
			bus(1'b1, 8'h4e, 8'hc3);
			for (n = 0; n < 40 && psel !== 1'b0; n++)
				@(posedge clk);
			// A write that never finishes counts against the run
			if (n >= 40)
			begin
				miscompares++;
				give_verdict();
			end
			check("apb write", t < 2 ? 32'hc3b2a190 : 32'h5a5a0005 + 32'(t * 256),
				u_irb_far_model.apb_mem[t][5]);
			rchk(8'h49, 8'h05);
		end
	endtask

	// Read-start without enable, and a slave error, leave data alone
	task automatic t_apb_refused;
		bus(1'b1, 8'h4b, 8'h11);
		bus(1'b1, 8'h48, 8'h02);
		check("psel idle", 32'h0, {31'h0, psel});
		rchk(8'h4b, 8'h11);
		err <= 1'b1;
		bus(1'b1, 8'h48, 8'h03);
		poll_done();
		rchk(8'h4b, 8'h11);
		err <= 1'b0;
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_ana_write();
		t_ana_read();
		t_ana_reserved();
		t_apb_read();
		t_apb_write();
		t_apb_refused();
		give_verdict();
	end
endmodule
`default_nettype wire
